//--- pisx_pkg.sv
// package: opcodes, shift modes, timing constants and carrier types for the product/immediate store unit
package pisx_pkg;

  // ==========================================================
  // opcode decode
  localparam logic [7:0] OPC_UPPER = 8'h8d;
  localparam logic [7:0] OPC_LOWER = 8'h8c;
  localparam logic [7:0] OPC_IMM = 8'hae;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;
  localparam int IND_BIT = 7;
  localparam int NXT_BIT = 3;
  localparam int DMA_W = 7;
  localparam int AUX_W = 3;
  localparam int DP_W = 9;
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;

  // ==========================================================
  // product shift modes
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_LEFT1 = 2'h1;
  localparam logic [1:0] PM_LEFT4 = 2'h2;
  localparam logic [1:0] PM_RIGHT6 = 2'h3;
  localparam int SHL_A = 1;
  localparam int SHL_B = 4;
  localparam int SHR = 6;

  // ==========================================================
  // program counter steps and cycle figures
  localparam logic [1:0] PC_STEP_ONE = 2'h1;
  localparam logic [1:0] PC_STEP_TWO = 2'h2;
  localparam int CNT_W = 16;
  localparam int WS_W = 4;
  localparam logic [CNT_W-1:0] EXT_ITER_BASE = 16'h0002;
  localparam logic [CNT_W-1:0] EXT_CODE_BASE = 16'h0002;
  localparam logic [CNT_W-1:0] SHARED_SINGLE = 16'h0001;
  localparam logic [CNT_W-1:0] SHARED_RPT = 16'h0002;
  localparam logic [CNT_W-1:0] INT_ITER = 16'h0001;

  typedef enum logic [1:0] {PISX_OP_NONE, PISX_OP_UPPER, PISX_OP_LOWER, PISX_OP_IMM} pisx_op_t;
  typedef enum logic [1:0] {PISX_IDLE, PISX_FETCH, PISX_OVER, PISX_ITER} pisx_state_t;

  typedef struct packed {
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } pisx_mem_wr_t;

endpackage : pisx_pkg

//--- pisx_pshift.sv
// product scaler: shifts the product register as the shift select asks
`timescale 1ns/1ps
module pisx_pshift (
  input wire logic [pisx_pkg::PROD_W-1:0] product_register_i,
  input wire logic [1:0] product_shift_select_i,
  output logic [pisx_pkg::PROD_W-1:0] shifted_o
);
  always_comb begin
    unique case (product_shift_select_i)
      pisx_pkg::PM_NONE: shifted_o = product_register_i;
      pisx_pkg::PM_LEFT1: shifted_o = product_register_i << pisx_pkg::SHL_A;
      pisx_pkg::PM_LEFT4: shifted_o = product_register_i << pisx_pkg::SHL_B;
      pisx_pkg::PM_RIGHT6: shifted_o = $signed(product_register_i) >>> pisx_pkg::SHR;
    endcase
  end
endmodule : pisx_pshift

//--- pisx_store_exec.sv
// decode and execute of the product-upper, product-lower and immediate-word stores
`timescale 1ns/1ps
// Contract
// - opcode 8d hi byte is product-upper store; bit 7 picks direct or indirect.
// - opcode 8c hi byte is product-lower store; indirect may load next aux pointer.
// - opcode ae hi byte is two-word immediate store; program counter steps two.
// - product-upper store writes shifter bits 31..16.
// - product-lower store writes shifter bits 15..0.
// - product stores leave product register and accumulator untouched.
// - right-six mode sign-fills the upper half's top bits.
// - left modes fill upper half's low bits from the lower half's top bits.
// - right-six mode fills lower half's top bits from upper half's low bits.
// - left modes zero-fill lower half's low bits.
// - immediate store writes the constant; accumulator and status untouched.
// - immediate store ignores single repeat and runs once.
// - single product store: 1, 2 shared, 2+d external, 4+d+p code external.
// - repeated product store: n, n+2 shared, 2n+nd external.
// - immediate store: 2, 3 shared, 3+d external, 5+d+2p code external.
// - shift select: 00 none, 01 left one, 10 left four, 11 right six.
module pisx_store_exec #(
  parameter int CNT_W = pisx_pkg::CNT_W,
  parameter int WS_W = pisx_pkg::WS_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_word_i,
  input wire logic [pisx_pkg::DP_W-1:0] page_pointer_i,
  input wire logic [15:0] ind_addr_i,
  input wire logic [CNT_W-1:0] single_repeat_i,
  input wire logic [31:0] product_register_i,
  input wire logic [1:0] product_shift_select_i,
  input wire logic operand_ext_i,
  input wire logic code_ext_i,
  input wire logic shared_single_access_ram_i,
  input wire logic [WS_W-1:0] data_wait_i,
  input wire logic [WS_W-1:0] prog_wait_i,
  input wire logic [15:0] prog_data_i,
  input wire logic prog_valid_i,
  output logic ready_o,
  output logic busy_o,
  output logic prog_req_o,
  output logic dmem_we_o,
  output pisx_pkg::pisx_mem_wr_t dmem_wr_o,
  output logic ind_step_o,
  output logic done_o,
  output logic [1:0] pc_step_o,
  output logic aux_load_o,
  output logic [pisx_pkg::AUX_W-1:0] next_aux_pointer_o
);

  // ==========================================================
  // decode
  function automatic pisx_pkg::pisx_op_t decode_op(input logic [15:0] w);
    unique case (w[pisx_pkg::OPC_HI:pisx_pkg::OPC_LO])
      pisx_pkg::OPC_UPPER: decode_op = pisx_pkg::PISX_OP_UPPER;
      pisx_pkg::OPC_LOWER: decode_op = pisx_pkg::PISX_OP_LOWER;
      pisx_pkg::OPC_IMM: decode_op = pisx_pkg::PISX_OP_IMM;
      default: decode_op = pisx_pkg::PISX_OP_NONE;
    endcase
  endfunction : decode_op

  function automatic logic [CNT_W-1:0] wx(input logic [WS_W-1:0] v);
    wx = CNT_W'(v);
  endfunction : wx

  pisx_pkg::pisx_op_t dec_op;
  logic issue;
  logic [CNT_W-1:0] over_d, iter_cost_d, n_d;
  assign dec_op = decode_op(insn_word_i);
  assign issue = ready_o && insn_valid_i && (dec_op != pisx_pkg::PISX_OP_NONE);

  // startup overhead and per-iteration cost per memory placement
  always_comb begin
    iter_cost_d = operand_ext_i ? pisx_pkg::EXT_ITER_BASE + wx(data_wait_i) : pisx_pkg::INT_ITER;
    n_d = (single_repeat_i == '0) ? CNT_W'(1) : single_repeat_i;
    if (dec_op == pisx_pkg::PISX_OP_IMM) begin
      n_d = CNT_W'(1);
      if (code_ext_i) begin
        over_d = (operand_ext_i ? pisx_pkg::EXT_CODE_BASE : '0) + wx(prog_wait_i) + wx(prog_wait_i);
      end else begin
        over_d = (shared_single_access_ram_i && !operand_ext_i) ? pisx_pkg::SHARED_SINGLE : '0;
      end
    end else if (code_ext_i) begin
      over_d = (operand_ext_i ? pisx_pkg::EXT_CODE_BASE : '0) + wx(prog_wait_i);
    end else if (shared_single_access_ram_i && !operand_ext_i) begin
      over_d = (n_d == CNT_W'(1)) ? pisx_pkg::SHARED_SINGLE : pisx_pkg::SHARED_RPT;
    end else begin
      over_d = '0;
    end
  end

  // ==========================================================
  // sequencer
  pisx_pkg::pisx_state_t st_q;
  pisx_pkg::pisx_op_t op_q;
  logic [15:0] word_q, imm_q, daddr_q;
  logic [CNT_W-1:0] over_q, cost_q, cyc_q, iter_q;
  logic last_cyc;
  assign last_cyc = (st_q == pisx_pkg::PISX_ITER) && (cyc_q == CNT_W'(1));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= pisx_pkg::PISX_IDLE;
      cyc_q <= '0;
      iter_q <= '0;
    end else begin
      unique case (st_q)
        pisx_pkg::PISX_IDLE: if (issue) begin
          iter_q <= n_d;
          if (dec_op == pisx_pkg::PISX_OP_IMM) begin
            st_q <= pisx_pkg::PISX_FETCH;
          end else if (over_d != '0) begin
            st_q <= pisx_pkg::PISX_OVER;
            cyc_q <= over_d;
          end else begin
            st_q <= pisx_pkg::PISX_ITER;
            cyc_q <= iter_cost_d;
          end
        end
        pisx_pkg::PISX_FETCH: if (prog_valid_i) begin
          st_q <= (over_q != '0) ? pisx_pkg::PISX_OVER : pisx_pkg::PISX_ITER;
          cyc_q <= (over_q != '0) ? over_q : cost_q;
        end
        pisx_pkg::PISX_OVER: begin
          if (cyc_q == CNT_W'(1)) begin
            st_q <= pisx_pkg::PISX_ITER;
            cyc_q <= cost_q;
          end else begin
            cyc_q <= cyc_q - CNT_W'(1);
          end
        end
        pisx_pkg::PISX_ITER: begin
          if (cyc_q != CNT_W'(1)) begin
            cyc_q <= cyc_q - CNT_W'(1);
          end else if (iter_q == CNT_W'(1)) begin
            st_q <= pisx_pkg::PISX_IDLE;
          end else begin
            iter_q <= iter_q - CNT_W'(1);
            cyc_q <= cost_q;
          end
        end
      endcase
    end
  end

  // instruction capture; direct address is page pointer joined to the 7-bit offset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_q <= pisx_pkg::PISX_OP_NONE;
      word_q <= '0;
      daddr_q <= '0;
      over_q <= '0;
      cost_q <= '0;
      pc_step_o <= '0;
    end else if (issue) begin
      op_q <= dec_op;
      word_q <= insn_word_i;
      daddr_q <= {page_pointer_i, insn_word_i[pisx_pkg::DMA_W-1:0]};
      over_q <= over_d;
      cost_q <= iter_cost_d;
      pc_step_o <= (dec_op == pisx_pkg::PISX_OP_IMM) ? pisx_pkg::PC_STEP_TWO : pisx_pkg::PC_STEP_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      imm_q <= '0;
    end else if (st_q == pisx_pkg::PISX_FETCH && prog_valid_i) begin
      imm_q <= prog_data_i;
    end
  end

  // ==========================================================
  // data path: product is only read, never written back
  logic [31:0] shifted;
  logic indirect;
  pisx_pshift u_pshift (
    .product_register_i(product_register_i),
    .product_shift_select_i(product_shift_select_i),
    .shifted_o(shifted)
  );
  assign indirect = word_q[pisx_pkg::IND_BIT];

  always_comb begin
    dmem_wr_o.addr = indirect ? ind_addr_i : daddr_q;
    unique case (op_q)
      pisx_pkg::PISX_OP_UPPER: dmem_wr_o.data = shifted[31:16];
      pisx_pkg::PISX_OP_LOWER: dmem_wr_o.data = shifted[15:0];
      default: dmem_wr_o.data = imm_q;
    endcase
  end

  assign ready_o = (st_q == pisx_pkg::PISX_IDLE);
  assign busy_o = !ready_o;
  assign prog_req_o = (st_q == pisx_pkg::PISX_FETCH);
  assign dmem_we_o = last_cyc;
  assign ind_step_o = last_cyc && indirect;
  assign done_o = last_cyc && (iter_q == CNT_W'(1));
  assign aux_load_o = done_o && indirect && word_q[pisx_pkg::NXT_BIT];
  assign next_aux_pointer_o = word_q[pisx_pkg::AUX_W-1:0];

  // ==========================================================
  // checks
  sequence s_imm_fetched;
    st_q == pisx_pkg::PISX_FETCH && prog_valid_i;
  endsequence
  sequence s_int_issue;
    issue && !operand_ext_i && !code_ext_i && !shared_single_access_ram_i;
  endsequence

  property p_dec_upper;
    @(posedge clk_i) disable iff (!rst_b_i)
    issue && insn_word_i[15:8] == 8'h8d |=> op_q == pisx_pkg::PISX_OP_UPPER && busy_o;
  endproperty
  a_dec_upper: assert property (p_dec_upper) else $error("upper store not decoded");

  property p_aux;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_o && word_q[7] && word_q[3] |-> aux_load_o && next_aux_pointer_o == word_q[2:0];
  endproperty
  a_aux: assert property (p_aux) else $error("next aux pointer not loaded");

  property p_imm_step;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_o && op_q == pisx_pkg::PISX_OP_IMM |-> pc_step_o == 2'h2;
  endproperty
  a_imm_step: assert property (p_imm_step) else $error("immediate store must step pc by two");

  property p_upper_data;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_UPPER && product_shift_select_i == 2'h0
      |-> dmem_wr_o.data == product_register_i[31:16];
  endproperty
  a_upper_data: assert property (p_upper_data) else $error("upper half data wrong");

  property p_lower_data;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_LOWER && product_shift_select_i == 2'h2
      |-> dmem_wr_o.data == {product_register_i[11:0], 4'h0};
  endproperty
  a_lower_data: assert property (p_lower_data) else $error("lower half data wrong");

  property p_sign_fill;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_UPPER && product_shift_select_i == 2'h3
      |-> dmem_wr_o.data[15:10] == {6{product_register_i[31]}};
  endproperty
  a_sign_fill: assert property (p_sign_fill) else $error("upper half not sign filled");

  property p_left_fill;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_UPPER && product_shift_select_i == 2'h1
      |-> dmem_wr_o.data[0] == product_register_i[15];
  endproperty
  a_left_fill: assert property (p_left_fill) else $error("upper half low bit not from lower half");

  property p_right_low;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_LOWER && product_shift_select_i == 2'h3
      |-> dmem_wr_o.data[15:10] == product_register_i[21:16];
  endproperty
  a_right_low: assert property (p_right_low) else $error("lower half top bits wrong");

  property p_zero_fill;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_LOWER && product_shift_select_i == 2'h1
      |-> dmem_wr_o.data[0] == 1'b0;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("lower half not zero filled");
  property p_imm_data;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_imm_fetched ##1 dmem_we_o |-> dmem_wr_o.data == $past(prog_data_i);
  endproperty
  a_imm_data: assert property (p_imm_data) else $error("immediate data wrong");
  property p_imm_once;
    @(posedge clk_i) disable iff (!rst_b_i)
    dmem_we_o && op_q == pisx_pkg::PISX_OP_IMM |-> done_o ##1 ready_o;
  endproperty
  a_imm_once: assert property (p_imm_once) else $error("immediate store repeated");
  property p_single_int;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_int_issue and (dec_op != pisx_pkg::PISX_OP_IMM && single_repeat_i <= 16'h0001) |=> dmem_we_o && done_o;
  endproperty
  a_single_int: assert property (p_single_int) else $error("internal product store not one cycle");
  property p_rpt_int;
    @(posedge clk_i) disable iff (!rst_b_i)
    s_int_issue and (dec_op != pisx_pkg::PISX_OP_IMM && single_repeat_i == 16'h0003)
      |=> dmem_we_o [*3] ##1 ready_o;
  endproperty
  a_rpt_int: assert property (p_rpt_int) else $error("repeated internal store not n cycles");
  property p_imm_int;
    @(posedge clk_i) disable iff (!rst_b_i)
    (s_int_issue and (dec_op == pisx_pkg::PISX_OP_IMM)) ##1 prog_valid_i |=> dmem_we_o && done_o;
  endproperty
  a_imm_int: assert property (p_imm_int) else $error("internal immediate store not two cycles");

endmodule : pisx_store_exec

//--- testbench.sv
// testbench: table-driven and hand-written checks of the product and immediate store unit
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // stimulus rows: loc = {operand external, code external, shared single-access block}
  typedef struct {
    logic [15:0] w;
    logic [1:0] pm;
    logic [31:0] prod;
    logic [2:0] loc;
    logic [3:0] d;
    logic [3:0] p;
    logic [15:0] n;
    int cyc;
  } pisx_row_t;
  logic clk_i;
  logic rst_b_i;
  logic insn_valid_i;
  logic [15:0] insn_word_i;
  logic [8:0] page_pointer_i;
  logic [15:0] ind_addr_i;
  logic [15:0] single_repeat_i;
  logic [31:0] product_register_i;
  logic [1:0] product_shift_select_i;
  logic operand_ext_i;
  logic code_ext_i;
  logic shared_single_access_ram_i;
  logic [3:0] data_wait_i;
  logic [3:0] prog_wait_i;
  logic [15:0] prog_data_i;
  logic prog_valid_i;
  logic ready_o;
  logic busy_o;
  logic prog_req_o;
  logic dmem_we_o;
  pisx_pkg::pisx_mem_wr_t dmem_wr_o;
  logic ind_step_o;
  logic done_o;
  logic [1:0] pc_step_o;
  logic aux_load_o;
  logic [2:0] next_aux_pointer_o;
  int errors = 0;
  int cmp_count = 0;
  int k;
  pisx_row_t rows[12] = '{
    '{16'h8d03, 2'h0, 32'hfe079844, 3'h0, 4'h0, 4'h0, 16'h0001, 1},
    '{16'h8c05, 2'h2, 32'hfe079844, 3'h0, 4'h0, 4'h0, 16'h0001, 1},
    '{16'h8d83, 2'h1, 32'hfe079844, 3'h1, 4'h0, 4'h0, 16'h0001, 2},
    '{16'h8c8d, 2'h3, 32'h12345678, 3'h4, 4'h2, 4'h0, 16'h0001, 4},
    '{16'h8d02, 2'h3, 32'h80000040, 3'h6, 4'h1, 4'h3, 16'h0001, 8},
    '{16'h8c01, 2'h1, 32'h0000c001, 3'h0, 4'h0, 4'h0, 16'h0003, 3},
    '{16'h8d81, 2'h0, 32'h7fff0001, 3'h1, 4'h0, 4'h0, 16'h0003, 5},
    '{16'h8c88, 2'h0, 32'h00015555, 3'h4, 4'h1, 4'h0, 16'h0002, 6},
    '{16'hae07, 2'h0, 32'h00007fff, 3'h0, 4'h0, 4'h0, 16'h0001, 2},
    '{16'hae87, 2'h3, 32'h00001111, 3'h1, 4'h0, 4'h0, 16'h0001, 3},
    '{16'hae05, 2'h0, 32'h0000a5a5, 3'h4, 4'h2, 4'h0, 16'h0001, 5},
    '{16'hae8d, 2'h0, 32'h00005a5a, 3'h6, 4'h1, 4'h1, 16'h0004, 8}};

  pisx_store_exec uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .insn_valid_i(insn_valid_i), .insn_word_i(insn_word_i),
    .page_pointer_i(page_pointer_i), .ind_addr_i(ind_addr_i), .single_repeat_i(single_repeat_i),
    .product_register_i(product_register_i), .product_shift_select_i(product_shift_select_i),
    .operand_ext_i(operand_ext_i), .code_ext_i(code_ext_i), .shared_single_access_ram_i(shared_single_access_ram_i),
    .data_wait_i(data_wait_i), .prog_wait_i(prog_wait_i), .prog_data_i(prog_data_i), .prog_valid_i(prog_valid_i),
    .ready_o(ready_o), .busy_o(busy_o), .prog_req_o(prog_req_o), .dmem_we_o(dmem_we_o), .dmem_wr_o(dmem_wr_o),
    .ind_step_o(ind_step_o), .done_o(done_o), .pc_step_o(pc_step_o), .aux_load_o(aux_load_o),
    .next_aux_pointer_o(next_aux_pointer_o));

  always #2.5 clk_i = ~clk_i;

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  function automatic logic [31:0] scale(input logic [31:0] v, input logic [1:0] m);
    case (m)
      2'h1: return v << 1;
      2'h2: return v << 4;
      2'h3: return $signed(v) >>> 6;
      default: return v;
    endcase
  endfunction : scale

  // steps to the next falling edge where a write is shown, bounded
  task automatic wait_write(input int lim);
    k = 1;
    while (dmem_we_o !== 1'b1) begin
      if (k >= lim) begin
        errors++;
        $display("MISMATCH at %0t: no write in time", $time);
        final_report();
      end
      k++;
      @(negedge clk_i);
    end
  endtask : wait_write

  task automatic run_op(input pisx_row_t r);
    int wr;
    logic imm;
    logic [31:0] sv;
    logic [15:0] ed;
    imm = (r.w[15:8] == 8'hae);
    sv = scale(r.prod, r.pm);
    ed = imm ? r.prod[15:0] : (r.w[15:8] == 8'h8d) ? sv[31:16] : sv[15:0];
    @(negedge clk_i);
    check(ready_o, 1'b1, "ready before issue");
    {insn_word_i, product_shift_select_i, product_register_i} = {r.w, r.pm, r.prod};
    {operand_ext_i, code_ext_i, shared_single_access_ram_i} = r.loc;
    {data_wait_i, prog_wait_i, single_repeat_i, prog_data_i} = {r.d, r.p, r.n, r.prod[15:0]};
    insn_valid_i = 1'b1;
    @(negedge clk_i);
    insn_valid_i = 1'b0;
    check(busy_o, 1'b1, "busy after issue");
    k = 1;
    wr = 0;
    while (done_o !== 1'b1) begin
      if (dmem_we_o === 1'b1) begin
        wr++;
        check(dmem_wr_o.addr, r.w[7] ? ind_addr_i : {page_pointer_i, r.w[6:0]}, "address");
        check(dmem_wr_o.data, ed, "data");
        check(ind_step_o, r.w[7], "indirect step");
      end
      if (k >= 200) begin
        errors++;
        $display("MISMATCH at %0t: no completion", $time);
        final_report();
      end
      k++;
      @(negedge clk_i);
    end
    check(dmem_we_o, 1'b1, "last write with done");
    check(dmem_wr_o.data, ed, "last data");
    check(k, r.cyc, "cycle count");
    check(wr + 1, imm ? 1 : (r.n == 0 ? 1 : r.n), "write count");
    check(pc_step_o, imm ? 2'h2 : 2'h1, "program counter step");
    check(aux_load_o, r.w[7] & r.w[3], "aux load");
    if (r.w[7] & r.w[3]) begin
      check(next_aux_pointer_o, r.w[2:0], "next aux");
    end
    $display("test op %h done", r.w);
  endtask : run_op

  // ==========================================================
  // main sequence
  initial begin
    {clk_i, rst_b_i, insn_valid_i, insn_word_i, single_repeat_i} = '0;
    {product_register_i, product_shift_select_i, operand_ext_i, code_ext_i} = '0;
    {shared_single_access_ram_i, data_wait_i, prog_wait_i, prog_data_i} = '0;
    page_pointer_i = 9'h004;
    ind_addr_i = 16'h0203;
    prog_valid_i = 1'b1;
    repeat (4) begin
      @(negedge clk_i);
      check({ready_o, dmem_we_o, done_o, pc_step_o}, 5'h10, "reset outputs");
    end
    rst_b_i = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      run_op(rows[i]);
    end
    // unknown opcode is ignored; offered only once the unit is idle again
    @(negedge clk_i);
    insn_word_i = 16'h8e03;
    insn_valid_i = 1'b1;
    repeat (4) begin
      @(negedge clk_i);
      insn_valid_i = 1'b0;
      check({ready_o, busy_o, dmem_we_o}, 3'h4, "unknown opcode");
    end
    $display("test unknown opcode done");
    // constant arrives late: no write until it has been fetched
    {insn_word_i, prog_valid_i, prog_data_i} = {16'hae10, 1'b0, 16'hedcb};
    {operand_ext_i, code_ext_i, shared_single_access_ram_i} = 3'h0;
    insn_valid_i = 1'b1;
    @(negedge clk_i);
    insn_valid_i = 1'b0;
    repeat (3) begin
      check({prog_req_o, dmem_we_o}, 2'h2, "waiting for constant");
      prog_data_i = ~prog_data_i;
      @(negedge clk_i);
    end
    {prog_valid_i, prog_data_i} = {1'b1, 16'h1234};
    @(negedge clk_i);
    prog_data_i = 16'h0f0f;
    wait_write(20);
    check(k, 1, "write after constant");
    check(dmem_wr_o.data, 16'h1234, "late constant");
    $display("test late constant done");
    // reset in mid-repeat stops the writes
    {insn_word_i, single_repeat_i} = {16'h8c01, 16'h0004};
    @(negedge clk_i);
    insn_valid_i = 1'b1;
    @(negedge clk_i);
    insn_valid_i = 1'b0;
    rst_b_i = 1'b0;
    @(negedge clk_i);
    check({ready_o, dmem_we_o, done_o, pc_step_o}, 5'h10, "mid-run reset");
    rst_b_i = 1'b1;
    run_op(rows[0]);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : testbench
